// *** shared/lsie_defs.svh ***
// Constants of the serial interrupt-enable block.
// Assumes inclusion by bare name from the package and the design.
`ifndef LSIE_DEFS_SVH
`define LSIE_DEFS_SVH

// ==========================================
// Register byte offsets
`define LSIE_OFS_ENABLE_SET 8'h00
`define LSIE_OFS_STATUS 8'h04
`define LSIE_OFS_MASK 8'h08

// ==========================================
// Bit positions of the enable and status layout
`define LSIE_BIT_FE 26
`define LSIE_BIT_OE 25
`define LSIE_BIT_PE 24
`define LSIE_BIT_ID 13
`define LSIE_BIT_RX 9

// ==========================================
// Implemented bits and reset values
`define LSIE_IMPL_MASK 32'h0700_2200
`define LSIE_RST_ENABLE 32'h0000_0000
`define LSIE_RST_STATUS 32'h0000_0000
`define LSIE_RST_MASK 32'h0700_2200

// ==========================================
// Bus constants and source count
`define LSIE_ADDR_W 8
`define LSIE_RESP_OKAY 2'h0
`define LSIE_RESP_SLVERR 2'h2
`define LSIE_NUM_SRC 5

`endif

// *** shared/lsie_pkg.sv ***
// Types of the serial interrupt-enable block.
// Assumes lsie_defs.svh on the include path.
`include "lsie_defs.svh"

package lsie_pkg;

  // ==========================================
  // Register select after address decode
  typedef enum logic [1:0] {
    LSIE_SEL_ENABLE = 2'h0,
    LSIE_SEL_STATUS = 2'h1,
    LSIE_SEL_MASK = 2'h3,
    LSIE_SEL_NONE = 2'h2
  } lsie_sel_t;

  // ==========================================
  // Whole state of the block
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    lsie_sel_t wsel;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] enable;
    logic [31:0] status;
    logic [31:0] mask;
    logic [`LSIE_NUM_SRC-1:0] irq_req;
    logic irq;
  } lsie_state_t;

endpackage

// *** hw/lsie_top.sv ***
// Interrupt-enable set register of a LIN/SCI serial module, with
// sticky event status, a mask and per-source and summary requests.
// Assumes event pulses and the LIN mode level come from logic on aclk.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "lsie_defs.svh"

// Overview of operation
// - Enable bit 26 lets a framing error raise an interrupt.
// - Enable bit 25 lets a receive overrun raise an interrupt.
// - Enable bit 24 lets a parity error raise an interrupt.
// - Framing, overrun and parity enables act in LIN and SCI mode.
// - Enable bit 13 lets a matching identifier interrupt, LIN only.
// - Enable bit 9 lets a completed received frame interrupt.
// - Writing 1 sets an enable, writing 0 keeps it, in both modes.
// - Reading an enable gives 1 when enabled, else 0, in both modes.
// - Bits 23 to 14 and 12 to 10 read zero and ignore writes.
module lsie_top
  import lsie_pkg::*;
#(
  parameter int ADDR_W = `LSIE_ADDR_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Operating mode
  input wire logic lin_mode,
  input wire logic protected_write_mode,
  // Receiver events, one-cycle pulses
  input wire logic framing_err_evt,
  input wire logic overrun_err_evt,
  input wire logic parity_err_evt,
  input wire logic id_match_evt,
  input wire logic rx_frame_evt,
  // Interrupt requests
  output logic framing_err_irq,
  output logic overrun_err_irq,
  output logic parity_err_irq,
  output logic id_match_irq,
  output logic rx_irq,
  output logic irq
);

  // ==========================================
  // Parameter check
  generate
    if (ADDR_W < `LSIE_ADDR_W) begin : g_bad_addr
      $error("lsie_top: ADDR_W too small for the register map");
    end
    if ((`LSIE_RST_MASK & ~`LSIE_IMPL_MASK) != 32'h0000_0000) begin : g_rst
      $error("lsie_top: mask reset touches reserved bits");
    end
    if (`LSIE_IMPL_MASK != ((32'h0000_0001 << `LSIE_BIT_FE)
        | (32'h0000_0001 << `LSIE_BIT_OE)
        | (32'h0000_0001 << `LSIE_BIT_PE)
        | (32'h0000_0001 << `LSIE_BIT_ID)
        | (32'h0000_0001 << `LSIE_BIT_RX))) begin : g_bad_map
      $error("lsie_top: implemented bits differ from the field map");
    end
  endgenerate

  // ==========================================
  // Helpers
  function automatic lsie_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] ofs_en;
    logic [ADDR_W-1:0] ofs_st;
    logic [ADDR_W-1:0] ofs_mk;
    ofs_en = ADDR_W'(`LSIE_OFS_ENABLE_SET);
    ofs_st = ADDR_W'(`LSIE_OFS_STATUS);
    ofs_mk = ADDR_W'(`LSIE_OFS_MASK);
    if (addr[ADDR_W-1:2] == ofs_en[ADDR_W-1:2]) begin
      return LSIE_SEL_ENABLE;
    end else if (addr[ADDR_W-1:2] == ofs_st[ADDR_W-1:2]) begin
      return LSIE_SEL_STATUS;
    end else if (addr[ADDR_W-1:2] == ofs_mk[ADDR_W-1:2]) begin
      return LSIE_SEL_MASK;
    end else begin
      return LSIE_SEL_NONE;
    end
  endfunction

  // Byte strobes widened to bit lanes, limited to implemented bits
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m & `LSIE_IMPL_MASK;
  endfunction

  // Event pulses placed into the status layout
  function automatic logic [31:0] evt_bits(
    input logic fe,
    input logic oe,
    input logic pe,
    input logic id,
    input logic rx
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    v[`LSIE_BIT_FE] = fe;
    v[`LSIE_BIT_OE] = oe;
    v[`LSIE_BIT_PE] = pe;
    v[`LSIE_BIT_ID] = id;
    v[`LSIE_BIT_RX] = rx;
    return v;
  endfunction

  // Pending requests; the identifier one only in LIN mode
  function automatic logic [31:0] pend_req(
    input logic [31:0] st,
    input logic [31:0] en,
    input logic lin
  );
    logic [31:0] v;
    v = st & en & `LSIE_IMPL_MASK;
    v[`LSIE_BIT_ID] = v[`LSIE_BIT_ID] && lin;
    return v;
  endfunction

  // ==========================================
  // State
  lsie_state_t s_r;
  lsie_state_t s_nxt;

  always_comb begin
    logic aw_fire;
    logic w_fire;
    logic ar_fire;
    logic [31:0] evt;
    logic [31:0] rd_clr;
    logic [31:0] wmask;
    logic [31:0] req;
    lsie_sel_t rsel;
    aw_fire = 1'b0;
    w_fire = 1'b0;
    ar_fire = 1'b0;
    evt = 32'h0000_0000;
    rd_clr = 32'h0000_0000;
    wmask = 32'h0000_0000;
    req = 32'h0000_0000;
    rsel = LSIE_SEL_NONE;
    s_nxt = s_r;

    aw_fire = s_axi_awvalid && s_r.awready;
    w_fire = s_axi_wvalid && s_r.wready;
    ar_fire = s_axi_arvalid && s_r.arready;

    // Event capture into the status layout
    evt = evt_bits(
      framing_err_evt,
      overrun_err_evt,
      parity_err_evt,
      id_match_evt && lin_mode,
      rx_frame_evt
    );

    // ----- Write channel -----
    if (aw_fire) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.wsel = decode(s_axi_awaddr);
    end
    if (w_fire) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_have && s_r.w_have) begin
      // Protected write mode behaves the same as normal mode
      wmask = lane_mask(s_r.wstrb);
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = `LSIE_RESP_OKAY;
      case (s_r.wsel)
        LSIE_SEL_ENABLE: begin
          s_nxt.enable = s_r.enable | (s_r.wdata & wmask);
        end
        LSIE_SEL_STATUS: begin
          s_nxt.bresp = `LSIE_RESP_OKAY;
        end
        LSIE_SEL_MASK: begin
          s_nxt.mask = (s_r.mask & ~wmask) | (s_r.wdata & wmask);
        end
        default: begin
          s_nxt.bresp = `LSIE_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end

    // ----- Read channel -----
    if (ar_fire) begin
      rsel = decode(s_axi_araddr);
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = `LSIE_RESP_OKAY;
      case (rsel)
        LSIE_SEL_ENABLE: begin
          s_nxt.rdata = s_r.enable & `LSIE_IMPL_MASK;
        end
        LSIE_SEL_STATUS: begin
          s_nxt.rdata = s_r.status & `LSIE_IMPL_MASK;
          rd_clr = `LSIE_IMPL_MASK;
        end
        LSIE_SEL_MASK: begin
          s_nxt.rdata = s_r.mask & `LSIE_IMPL_MASK;
        end
        default: begin
          s_nxt.rdata = 32'h0000_0000;
          s_nxt.rresp = `LSIE_RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Sticky status: a new event beats the read clear
    s_nxt.status = ((s_r.status & ~rd_clr) | evt) & `LSIE_IMPL_MASK;

    // Requests: flag AND enable; the summary also AND mask
    req = pend_req(s_r.status, s_r.enable, lin_mode);
    s_nxt.irq_req[4] = req[`LSIE_BIT_FE];
    s_nxt.irq_req[3] = req[`LSIE_BIT_OE];
    s_nxt.irq_req[2] = req[`LSIE_BIT_PE];
    s_nxt.irq_req[1] = req[`LSIE_BIT_ID];
    s_nxt.irq_req[0] = req[`LSIE_BIT_RX];
    s_nxt.irq = |(req & s_r.mask);

    // Ready flags follow the next occupancy
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
    s_nxt.arready = !s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r.awready <= 1'b0;
      s_r.wready <= 1'b0;
      s_r.aw_have <= 1'b0;
      s_r.w_have <= 1'b0;
      s_r.wsel <= LSIE_SEL_NONE;
      s_r.wdata <= 32'h0000_0000;
      s_r.wstrb <= 4'h0;
      s_r.bvalid <= 1'b0;
      s_r.bresp <= `LSIE_RESP_OKAY;
      s_r.arready <= 1'b0;
      s_r.rvalid <= 1'b0;
      s_r.rdata <= 32'h0000_0000;
      s_r.rresp <= `LSIE_RESP_OKAY;
      s_r.enable <= `LSIE_RST_ENABLE;
      s_r.status <= `LSIE_RST_STATUS;
      s_r.mask <= `LSIE_RST_MASK;
      s_r.irq_req <= '0;
      s_r.irq <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================
  // Outputs
  assign s_axi_awready = s_r.awready;
  assign s_axi_wready = s_r.wready;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign framing_err_irq = s_r.irq_req[4];
  assign overrun_err_irq = s_r.irq_req[3];
  assign parity_err_irq = s_r.irq_req[2];
  assign id_match_irq = s_r.irq_req[1];
  assign rx_irq = s_r.irq_req[0];
  assign irq = s_r.irq;

endmodule

// *** dv/lsie_sva.sv ***
// Checker of the interrupt-enable block, bound to lsie_top.
// Assumes one clock domain with a sync active-low reset.
`timescale 1ns/1ps
`include "lsie_defs.svh"
module lsie_sva (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  // Mode and events
  input wire logic lin_mode,
  input wire logic framing_err_evt,
  input wire logic rx_frame_evt,
  // Requests
  input wire logic framing_err_irq,
  input wire logic overrun_err_irq,
  input wire logic parity_err_irq,
  input wire logic id_match_irq,
  input wire logic rx_irq,
  input wire logic irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic bv_r;
  logic new_b;
  always_ff @(posedge aclk) begin
    bv_r <= s_axi_bvalid;
  end
  assign new_b = s_axi_bvalid & ~bv_r;
  a_fe_rise: assert property (
    $rose(framing_err_irq) |-> $past(framing_err_evt, 2) || $past(new_b))
    else $error("framing request rose without cause");
  a_rx_rise: assert property (
    $rose(rx_irq) |-> $past(rx_frame_evt, 2) || $past(new_b))
    else $error("receive request rose without cause");
  a_fe_fall: assert property (
    $fell(framing_err_irq) |-> $past(s_axi_rvalid))
    else $error("framing request fell without read");
  a_read_lat: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_resv_zero: assert property (
    s_axi_rvalid |-> (s_axi_rdata & ~`LSIE_IMPL_MASK) == 32'h0000_0000)
    else $error("reserved bit read as one");
  a_id_lin: assert property (
    id_match_irq |-> $past(lin_mode))
    else $error("identifier request outside lin mode");
  a_irq_src: assert property (
    irq |-> framing_err_irq || overrun_err_irq || parity_err_irq
      || id_match_irq || rx_irq)
    else $error("summary request without source");
  a_wr_okay: assert property (
    $rose(s_axi_bvalid) |-> s_axi_bresp == `LSIE_RESP_OKAY)
    else $error("enable write refused");
endmodule

// *** dv/lsie_node.sv ***
// Serial-node model: turns a bench request into event pulses.
// Assumes requests arrive on the rising edge of aclk.
`timescale 1ns/1ps
module lsie_node (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request and delay in cycles
  input wire logic [4:0] req,
  input wire logic [3:0] dly,
  // Receiver events
  output logic [4:0] evt
);
  logic [4:0] pend_r;
  logic [3:0] cnt_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= 5'h0;
      cnt_r <= 4'h0;
      evt <= 5'h0;
    end else if (req != 5'h0) begin
      pend_r <= req;
      cnt_r <= dly;
      evt <= 5'h0;
    end else begin
      evt <= (cnt_r == 4'h0) ? pend_r : 5'h0;
      if (cnt_r == 4'h0) pend_r <= 5'h0;
      else cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule

// *** dv/lsie_top_tb.sv ***
// Self-checking bench of lsie_top with a serial-node model.
// Assumes package, defines and checker are compiled first.
`timescale 1ns/1ps
`include "lsie_defs.svh"
module lsie_top_tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, lin_mode, irq;
  logic protected_write_mode, framing_err_evt, overrun_err_evt;
  logic parity_err_evt, id_match_evt, rx_frame_evt, framing_err_irq;
  logic overrun_err_irq, parity_err_irq, id_match_irq, rx_irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, en, st, msk, w, d;
  logic [3:0] s_axi_wstrb, dly;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] req;
  int errors, num_checks, cyc;
  lsie_top lsie_top_inst (.*);
  lsie_node lsie_node_inst (.aclk, .aresetn, .req, .dly,
    .evt({framing_err_evt, overrun_err_evt, parity_err_evt, id_match_evt,
      rx_frame_evt}));
  always #20 aclk = ~aclk;
  // ==========================================
  // Expectations
  function automatic logic [31:0] evbits(logic [4:0] v, logic lin);
    return {5'h0, v[4:2], 10'h0, v[1] & lin, 3'h0, v[0], 9'h0};
  endfunction
  function automatic logic [4:0] srcs(logic [31:0] s, e, logic lin);
    return {s[26:24] & e[26:24], s[13] & e[13] & lin, s[9] & e[9]};
  endfunction
  // ==========================================
  // Bus and check tasks
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic fire(input logic [4:0] v);
    req <= v;
    dly <= 4'($urandom % 8);
    @(posedge aclk);
    req <= 5'h0;
    repeat (12) @(posedge aclk);
    st = st | evbits(v, lin_mode);
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      conclude();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    aclk = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, req, dly} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, lin_mode} = 0;
    {s_axi_awprot, s_axi_arprot, protected_write_mode} = 0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
    {errors, num_checks, cyc, en, st} = 0;
    msk = `LSIE_RST_MASK;
    void'($urandom(32'hda99_90b2));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`LSIE_OFS_ENABLE_SET);
    chk("enable", d, en);
    rd(8'h0c);
    chk("unmapped", {d[31:2], r}, {30'h0, `LSIE_RESP_SLVERR});
    wr(`LSIE_OFS_STATUS, 32'hffff_ffff);
    chk("bresp", r, `LSIE_RESP_OKAY);
    rd(`LSIE_OFS_STATUS);
    chk("status", d, st);
    for (int i = 0; i < 16; i++) begin
      lin_mode <= 1'($urandom);
      protected_write_mode <= 1'($urandom);
      w = (i == 0) ? 32'h0 : $urandom & $urandom & $urandom;
      wr(`LSIE_OFS_ENABLE_SET, w);
      en = en | (w & `LSIE_IMPL_MASK);
      chk("bresp", r, `LSIE_RESP_OKAY);
      rd(`LSIE_OFS_ENABLE_SET);
      chk("enable", d, en);
      if (i % 4 == 3) begin
        w = $urandom;
        wr(`LSIE_OFS_MASK, w);
        msk = w & `LSIE_IMPL_MASK;
      end
      rd(`LSIE_OFS_MASK);
      chk("mask", d, msk);
      fire(5'($urandom));
      chk("sources", {framing_err_irq, overrun_err_irq, parity_err_irq,
        id_match_irq, rx_irq}, srcs(st, en, lin_mode));
      chk("irq", irq, |(st & en & msk));
      rd(`LSIE_OFS_STATUS);
      chk("status", d, st);
      chk("rresp", r, `LSIE_RESP_OKAY);
      st = 0;
      repeat (2) @(posedge aclk);
      chk("cleared", {irq, framing_err_irq, overrun_err_irq, parity_err_irq,
        id_match_irq, rx_irq}, 0);
    end
    conclude();
  end
endmodule
bind lsie_top lsie_sva lsie_sva_inst (.*);
